// ===== design/wwdt_core.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module wwdt_core #(
    parameter int unsigned RATE_SCALE_DOWN = 0 // Shortens periods for tests
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic sys_rst, // Async reset, active high
    input wire logic [7:0] address, // Byte address
    input wire logic read, // Read request
    input wire logic write, // Write request
    input wire logic [31:0] writedata, // Write data
    input wire logic [3:0] byteenable, // Byte lanes
    output logic [31:0] readdata, // Read data
    output logic waitrequest, // Stall, low on the answer cycle
    input wire logic internal_ref_tick, // Reference clock tick
    input wire logic oscillator_tick, // Oscillator clock tick
    input wire logic osc_qualified, // Oscillator is good
    input wire logic debug_halt_mode, // Part halted in debug
    input wire logic special_mode, // Special operating mode
    output wwdt_pkg::wwdt_clksel_t clock_select_q, // Clock select state
    output logic tick_freeze, // Freeze periodic tick counter
    output logic system_reset_req // Watchdog system reset
);
    import wwdt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    wwdt_ctrl_t ctrl_reg, ctrl_next;
    wwdt_clksel_t cs_reg, cs_next;
    logic write_lock_flag_reg, write_lock_flag_next;
    logic written_reg, written_next;
    logic armed_reg, armed_next;
    logic rearm_reg, rearm_next;
    logic oscq_reg;
    logic [CNT_W-1:0] count_reg, count_next;
    logic rst_reg, rst_next;
    logic freeze_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [IDX_W-1:0] idx;
    logic aligned, wr_ack, rd_load, lane0;
    logic clk_wr, ctrl_wr, svc_wr, write_lock_flag_wr;
    logic [7:0] wbyte;
    wwdt_ctrl_t wr_ctrl;
    wwdt_clksel_t wr_cs;

    // Answer one cycle after the request appears
    assign idx = address[7:2];
    assign aligned = (address[1:0] == WORD_ALIGN);
    assign wr_ack = write & ~wait_reg;
    assign rd_load = read & wait_reg;
    assign lane0 = byteenable[0];
    assign wbyte = writedata[7:0];
    assign wr_ctrl = wwdt_ctrl_t'(wbyte);
    assign wr_cs = wwdt_clksel_t'(wbyte);
    assign clk_wr = wr_ack & lane0 & aligned & (idx == IDX_CLKSEL);
    assign ctrl_wr = wr_ack & lane0 & aligned & (idx == IDX_CTRL);
    assign svc_wr = wr_ack & lane0 & aligned & (idx == IDX_SVC);
    assign write_lock_flag_wr = wr_ack & lane0 & aligned & (idx == IDX_WRITE_LOCK_FLAG);
    assign wait_next = ~((read | write) & wait_reg);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic ctrl_locked, ctrl_take, restart_ctrl, running;

    assign ctrl_locked = ~special_mode & written_reg;
    assign ctrl_take = ctrl_wr & ~wr_ctrl.write_mask_bit & ~ctrl_locked;
    assign restart_ctrl = ctrl_take & (wr_ctrl.rate_select != RATE_OFF);
    assign running = (ctrl_reg.rate_select != RATE_OFF);
    assign written_next = written_reg | ctrl_take;

    // Mask bit is write-only, never stored
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next.stop_in_debug = wr_ctrl.stop_in_debug;
        end
        if (ctrl_take) begin
            ctrl_next.window_mode = wr_ctrl.window_mode;
            ctrl_next.rate_select = wr_ctrl.rate_select;
        end
    end

    // ------------------------------------------------------------
    // Period and window
    // ------------------------------------------------------------
    logic dbg_override, window_eff, frozen, tick_sel;
    logic [4:0] base_shift, eff_shift;
    logic [CNT_W:0] period, win_start, count_ext;
    logic win_open, expire;

    assign dbg_override = running & debug_halt_mode
        & ~ctrl_reg.stop_in_debug & special_mode;
    assign base_shift = dbg_override ? SHIFT_MAX
        : wwdt_rate_shift(ctrl_reg.rate_select);
    assign eff_shift = base_shift - 5'(RATE_SCALE_DOWN);
    assign window_eff = ctrl_reg.window_mode & ~dbg_override;
    assign period = (CNT_W+1)'(1) << eff_shift;
    assign win_start = period - (period >> QUARTER_SHIFT);
    assign count_ext = {1'b0, count_reg};
    assign win_open = (count_ext >= win_start);
    assign frozen = ctrl_reg.stop_in_debug & debug_halt_mode;
    assign tick_sel = cs_reg.cop_clock_sel_low ? oscillator_tick
        : internal_ref_tick;
    assign expire = running & tick_sel & ~frozen
        & (count_ext >= (period - (CNT_W+1)'(1)));

    // ------------------------------------------------------------
    // Service sequence
    // ------------------------------------------------------------
    logic early, bad_val, fire_ok, arm_hit;

    assign early = running & window_eff & svc_wr & ~win_open;
    // Unknown service values while running are treated as a failed service
    assign bad_val = running & svc_wr & (wbyte != SVC_ARM)
        & (wbyte != SVC_FIRE);
    assign arm_hit = running & svc_wr & (wbyte == SVC_ARM) & ~early;
    assign fire_ok = running & svc_wr & (wbyte == SVC_FIRE)
        & armed_reg & ~early;

    always_comb begin
        armed_next = armed_reg;
        if (fire_ok | restart_ctrl | ~running) begin
            armed_next = 1'b0;
        end else if (arm_hit) begin
            armed_next = 1'b1;
        end
    end

    // Counter restarts on fire, new rate or expiry
    always_comb begin
        count_next = count_reg;
        if (fire_ok | restart_ctrl | ~running | expire) begin
            count_next = '0;
        end else if (tick_sel & ~frozen) begin
            count_next = count_reg + CNT_W'(1);
        end
    end

    // Reset request holds until the system reset clears it
    assign rst_next = rst_reg | expire | early | bad_val;

    // ------------------------------------------------------------
    // Clock select register
    // ------------------------------------------------------------
    logic osc_drop, cs_open, cs_all, cs_norm, cs_wd, rearm_use;

    assign osc_drop = oscq_reg & ~osc_qualified;
    assign cs_open = clk_wr & ~write_lock_flag_reg;
    assign cs_all = cs_open & special_mode;
    assign cs_norm = cs_open & ~special_mode;
    assign cs_wd = cs_norm & ~written_reg;
    assign rearm_use = cs_norm & written_reg & rearm_reg
        & wr_cs.cop_clock_sel_low;
    // Hardware set wins over a use in the same cycle
    assign rearm_next = osc_drop | (rearm_reg & ~rearm_use);
    assign write_lock_flag_next = write_lock_flag_wr ? wbyte[0] : write_lock_flag_reg;

    always_comb begin
        cs_next = cs_reg;
        if (cs_all) begin
            cs_next = wr_cs;
        end
        if (cs_norm) begin
            cs_next.pll_output_select = wr_cs.pll_output_select;
            cs_next.pseudo_stop_enable = wr_cs.pseudo_stop_enable;
            cs_next.tick_run_in_pseudostop = wr_cs.tick_run_in_pseudostop;
            cs_next.watchdog_run_in_pseudostop =
                wr_cs.watchdog_run_in_pseudostop;
            cs_next.tick_clock_source = wr_cs.tick_clock_source;
        end
        if (cs_wd) begin
            cs_next.clock_source_adjust_bit = wr_cs.clock_source_adjust_bit;
            cs_next.cop_clock_sel_high = wr_cs.cop_clock_sel_high;
            cs_next.cop_clock_sel_low = wr_cs.cop_clock_sel_low;
        end
        // one more set after a clear
        if (rearm_use) begin
            cs_next.cop_clock_sel_low = 1'b1;
        end
        // drop clears only the low bit
        if (osc_drop) begin
            cs_next.cop_clock_sel_low = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wwdt_stat_t stat;
    logic [7:0] rd_byte;

    assign stat = '{rsvd: 3'h0, rearm_allowed: rearm_reg,
        ctrl_written: written_reg, service_armed: armed_reg,
        window_open: win_open, running: running};
    // Unmapped and misaligned reads return zero
    assign rd_byte = ~aligned ? 8'h00
        : (idx == IDX_CLKSEL) ? cs_reg
        : (idx == IDX_CTRL) ? ctrl_reg
        : (idx == IDX_WRITE_LOCK_FLAG) ? {7'h00, write_lock_flag_reg}
        : (idx == IDX_STAT) ? stat
        : 8'h00;
    assign rdata_next = rd_load ? {24'h000000, rd_byte} : rdata_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            write_lock_flag_reg <= WRITE_LOCK_FLAG_RST;
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            write_lock_flag_reg <= write_lock_flag_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= wwdt_ctrl_t'(CTRL_RST);
            written_reg <= 1'b0;
            armed_reg <= 1'b0;
            count_reg <= '0;
            rst_reg <= 1'b0;
            freeze_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            written_reg <= written_next;
            armed_reg <= armed_next;
            count_reg <= count_next;
            rst_reg <= rst_next;
            freeze_reg <= frozen;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_reg <= wwdt_clksel_t'(CLKSEL_RST);
            rearm_reg <= 1'b0;
            oscq_reg <= 1'b0;
        end else begin
            cs_reg <= cs_next;
            rearm_reg <= rearm_next;
            oscq_reg <= osc_qualified;
        end
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
    assign clock_select_q = cs_reg;
    assign tick_freeze = freeze_reg;
    assign system_reset_req = rst_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // early service check
    a_early_svc_reset: assert property (@(posedge clk)
        disable iff (sys_rst) early |=> system_reset_req)
        else $error("early service no reset");

    a_fire_restart: assert property (@(posedge clk) disable iff (sys_rst)
        (svc_wr && wbyte == SVC_FIRE && armed_reg && running && !early)
        |=> count_reg == '0 && !armed_reg)
        else $error("fire did not restart");

    a_debug_freeze: assert property (@(posedge clk) disable iff (sys_rst)
        (frozen && !ctrl_wr && !svc_wr && running) |=> $stable(count_reg)
        && tick_freeze) else $error("counter moved in debug freeze");

    a_mask_keeps: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_wr && wr_ctrl.write_mask_bit) |=> $stable(written_reg)
        && ctrl_reg.rate_select == $past(ctrl_reg.rate_select)
        && ctrl_reg.window_mode == $past(ctrl_reg.window_mode))
        else $error("masked write changed mode");

    a_rate_enable: assert property (@(posedge clk) disable iff (sys_rst)
        restart_ctrl |=> running && count_reg == '0)
        else $error("rate write did not start");

    a_expiry_reset: assert property (@(posedge clk) disable iff (sys_rst)
        expire |=> system_reset_req ##1 system_reset_req)
        else $error("expiry without reset");

    a_debug_longest: assert property (@(posedge clk)
        disable iff (sys_rst) (running && debug_halt_mode
        && !ctrl_reg.stop_in_debug && special_mode)
        |-> base_shift == SHIFT_MAX && !window_eff)
        else $error("debug override not applied");

    a_rate_table: assert property (@(posedge clk) disable iff (sys_rst)
        (!dbg_override && ctrl_reg.rate_select == 3'h1)
        |-> base_shift == SHIFT_R1) else $error("wrong rate shift");

    a_lock_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_wr && write_lock_flag_reg && !osc_drop) |=> $stable(clock_select_q))
        else $error("write landed while locked");

    a_osc_drop: assert property (@(posedge clk) disable iff (sys_rst)
        (osc_drop && !cs_open) |=> !clock_select_q.cop_clock_sel_low
        && rearm_reg && clock_select_q.cop_clock_sel_high
        == $past(clock_select_q.cop_clock_sel_high))
        else $error("oscillator drop handling wrong");

endmodule : wwdt_core

`default_nettype wire

// ===== design/wwdt_pkg.sv
package wwdt_pkg;

    // ------------------------------------------------------------
    // Register map (word index, byte address is index times four)
    // ------------------------------------------------------------
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_CLKSEL = 6'h09;
    localparam logic [5:0] IDX_CTRL = 6'h0A;
    localparam logic [5:0] IDX_SVC = 6'h0B;
    localparam logic [5:0] IDX_WRITE_LOCK_FLAG = 6'h0C;
    localparam logic [5:0] IDX_STAT = 6'h0D;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // ------------------------------------------------------------
    // Service codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SVC_ARM = 8'h55;
    localparam logic [7:0] SVC_FIRE = 8'hAA;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    localparam logic WRITE_LOCK_FLAG_RST = 1'b0;
    localparam logic [2:0] RATE_OFF = 3'h0;

    // ------------------------------------------------------------
    // Time-out table, in powers of two of watchdog clock cycles
    // ------------------------------------------------------------
    localparam int CNT_W = 24;
    localparam logic [4:0] SHIFT_R1 = 5'h0E;
    localparam logic [4:0] SHIFT_R2 = 5'h10;
    localparam logic [4:0] SHIFT_R3 = 5'h12;
    localparam logic [4:0] SHIFT_R4 = 5'h14;
    localparam logic [4:0] SHIFT_R5 = 5'h16;
    localparam logic [4:0] SHIFT_R6 = 5'h17;
    localparam logic [4:0] SHIFT_MAX = 5'h18;
    localparam logic [4:0] QUARTER_SHIFT = 5'h02;

    // Control register layout
    typedef struct packed {
        logic window_mode;
        logic stop_in_debug;
        logic write_mask_bit;
        logic [1:0] rsvd;
        logic [2:0] rate_select;
    } wwdt_ctrl_t;

    // Clock select register layout
    typedef struct packed {
        logic pll_output_select;
        logic pseudo_stop_enable;
        logic clock_source_adjust_bit;
        logic tick_run_in_pseudostop;
        logic watchdog_run_in_pseudostop;
        logic cop_clock_sel_high;
        logic tick_clock_source;
        logic cop_clock_sel_low;
    } wwdt_clksel_t;

    // Status register layout
    typedef struct packed {
        logic [2:0] rsvd;
        logic rearm_allowed;
        logic ctrl_written;
        logic service_armed;
        logic window_open;
        logic running;
    } wwdt_stat_t;

    function automatic logic [4:0] wwdt_rate_shift(input logic [2:0] r);
        case (r)
            3'h1: wwdt_rate_shift = SHIFT_R1;
            3'h2: wwdt_rate_shift = SHIFT_R2;
            3'h3: wwdt_rate_shift = SHIFT_R3;
            3'h4: wwdt_rate_shift = SHIFT_R4;
            3'h5: wwdt_rate_shift = SHIFT_R5;
            3'h6: wwdt_rate_shift = SHIFT_R6;
            default: wwdt_rate_shift = SHIFT_MAX;
        endcase
    endfunction : wwdt_rate_shift

endpackage : wwdt_pkg

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import wwdt_pkg::*;
    localparam int SCALE = 10;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic internal_ref_tick = 1'b0;
    logic oscillator_tick = 1'b0;
    logic osc_qualified = 1'b1;
    logic debug_halt_mode = 1'b0;
    logic special_mode = 1'b0;
    wwdt_clksel_t clock_select_q;
    logic tick_freeze;
    logic system_reset_req;
    logic src_osc = 1'b0;
    logic [31:0] rng = 32'hB1FE;
    logic [7:0] q;
    logic [7:0] m_clk;
    logic [7:0] m_ctrl;
    bit m_done;
    bit m_rearm;
    bit m_write_lock_flag;
    int cyc = 0;
    int t0 = 0;
    int n_errors = 0;
    int comparisons = 0;
    int rshift[7] = '{14, 16, 18, 20, 22, 23, 24};

    // Scaled down so the slowest rate still fits the run
    wwdt_core #(.RATE_SCALE_DOWN(SCALE)) u_wwdt_core (.clk(clk),
        .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .internal_ref_tick(internal_ref_tick),
        .oscillator_tick(oscillator_tick), .osc_qualified(osc_qualified),
        .debug_halt_mode(debug_halt_mode), .special_mode(special_mode),
        .clock_select_q(clock_select_q), .tick_freeze(tick_freeze),
        .system_reset_req(system_reset_req));

    always #5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction : xs

    // Selected source ticks every cycle, the other one randomly
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rng <= xs(rng);
        internal_ref_tick <= src_osc ? rng[0] : 1'b1;
        oscillator_tick <= src_osc ? 1'b1 : rng[0];
        if (cyc > 100000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    // Request held until waitrequest is sampled low, then released
    task automatic bus(input logic we, input logic [5:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        write <= we;
        read <= ~we;
        address <= {idx, WORD_ALIGN};
        writedata <= {24'h0, d};
        byteenable <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata[7:0];
        if (we) t0 = cyc;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            conclude();
        end
        @(posedge clk);
    endtask : bus

    // Model of the clock select write permissions, then read back
    task automatic wr_clk(input logic [7:0] d);
        logic [7:0] m;
        m = (special_mode || !m_done) ? 8'hFF : 8'hDA;
        if (!m_write_lock_flag && m_rearm && d[0] && m == 8'hDA) begin
            m[0] = 1'b1;
            m_rearm = 0;
        end
        if (!m_write_lock_flag) m_clk = (m_clk & ~m) | (d & m);
        bus(1'b1, IDX_CLKSEL, d);
        bus(1'b0, IDX_CLKSEL, 8'h00);
        chk8("clock_select", m_clk, q);
        chk8("clock_select_q", m_clk, clock_select_q);
    endtask : wr_clk

    // Model of the one permitted control write and its mask bit
    task automatic wr_ctrl(input logic [7:0] d);
        if (d[5] || (m_done && !special_mode)) begin
            m_ctrl[6] = d[6];
        end else begin
            m_ctrl = d & 8'hC7;
            m_done = 1;
        end
        bus(1'b1, IDX_CTRL, d);
        bus(1'b0, IDX_CTRL, 8'h00);
        chk8("watchdog_control", m_ctrl, q);
    endtask : wr_ctrl

    task automatic do_reset();
        sys_rst <= 1'b1;
        debug_halt_mode <= 1'b0;
        special_mode <= 1'b0;
        // Back to the reference source, which ticks every cycle
        src_osc <= 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        m_clk = CLKSEL_RST;
        m_ctrl = CTRL_RST;
        m_done = 0;
        m_rearm = 0;
        m_write_lock_flag = 0;
        chk1("reset_idle", 1'b0, system_reset_req);
    endtask : do_reset

    task automatic expect_expiry(input int base, input int per);
        while (system_reset_req !== 1'b1 && cyc - base < per + 20)
            @(posedge clk);
        chk1("expiry_time", 1'b1,
             (cyc - base >= per) && (cyc - base <= per + 4));
    endtask : expect_expiry

    task automatic hold_quiet(input int n);
        repeat (n) @(posedge clk);
        chk1("no_reset", 1'b0, system_reset_req);
    endtask : hold_quiet

    task automatic svc_at(input int c);
        while (cyc < c) @(posedge clk);
        bus(1'b1, IDX_SVC, SVC_ARM);
        bus(1'b1, IDX_SVC, SVC_ARM);
        bus(1'b1, IDX_SVC, SVC_FIRE);
    endtask : svc_at

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int base;
        do_reset();
        bus(1'b0, IDX_CTRL, 8'h00);
        chk8("ctrl_reset", CTRL_RST, q);
        bus(1'b0, IDX_CLKSEL, 8'h00);
        chk8("clksel_reset", CLKSEL_RST, q);
        bus(1'b0, 6'h3F, 8'h00);
        chk8("unmapped", 8'h00, q);
        wr_clk(rng[7:0]);
        // masked write leaves the one write unused
        wr_ctrl(8'hE7);
        wr_clk(rng[15:8]);
        bus(1'b1, IDX_WRITE_LOCK_FLAG, 8'h01);
        m_write_lock_flag = 1;
        wr_clk(~m_clk);
        bus(1'b1, IDX_WRITE_LOCK_FLAG, 8'h00);
        m_write_lock_flag = 0;
        wr_clk(rng[7:0] | 8'h05);
        // adjust and watchdog clock bits lock
        wr_ctrl(8'h40);
        wr_clk(~m_clk);
        wr_ctrl(8'h07);
        // oscillator loss clears low select only
        osc_qualified <= 1'b0;
        repeat (3) @(posedge clk);
        osc_qualified <= 1'b1;
        m_clk[0] = 1'b0;
        m_rearm = 1;
        bus(1'b0, IDX_STAT, 8'h00);
        chk8("status", 8'h18, q);
        wr_clk(m_clk);
        wr_clk(m_clk | 8'h01);
        wr_clk(m_clk & 8'hFE);
        special_mode <= 1'b1;
        @(posedge clk);
        wr_clk(8'h00);
        for (int r = 1; r <= 7; r++) begin
            do_reset();
            src_osc <= r[0];
            wr_clk({7'h0, r[0]});
            wr_ctrl(8'(r));
            expect_expiry(t0, 1 << (rshift[r-1] - SCALE));
        end
        do_reset();
        wr_ctrl(8'h00);
        hold_quiet(40);
        // service pairs, then a lone 0xAA is ignored
        do_reset();
        wr_ctrl(8'h01);
        repeat (3) svc_at(t0 + 2);
        base = t0;
        bus(1'b1, IDX_SVC, SVC_FIRE);
        expect_expiry(base, 16);
        // window: late services pass, an early one resets
        do_reset();
        wr_ctrl(8'h82);
        repeat (2) svc_at(t0 + 50);
        chk1("window_ok", 1'b0, system_reset_req);
        svc_at(t0 + 10);
        chk1("early_service", 1'b1, system_reset_req);
        do_reset();
        wr_ctrl(8'h41);
        debug_halt_mode <= 1'b1;
        repeat (2) @(posedge clk);
        chk1("tick_freeze", 1'b1, tick_freeze);
        hold_quiet(60);
        debug_halt_mode <= 1'b0;
        repeat (20) @(posedge clk);
        chk1("resume_expiry", 1'b1, system_reset_req);
        // special debug run ignores rate and window
        do_reset();
        special_mode <= 1'b1;
        debug_halt_mode <= 1'b1;
        @(posedge clk);
        wr_ctrl(8'h81);
        chk1("no_freeze", 1'b0, tick_freeze);
        bus(1'b1, IDX_SVC, SVC_ARM);
        bus(1'b1, IDX_SVC, SVC_FIRE);
        hold_quiet(100);
        // Any other service value while running is a failed service
        bus(1'b1, IDX_SVC, 8'h3C);
        chk1("bad_service", 1'b1, system_reset_req);
        conclude();
    end

endmodule : tb

`default_nettype wire
